// File: logic/vrc_pkg.sv
// Package for the VC0 resource control register block.
// Assumes a 32-bit AXI4-Lite register bus and a single clock domain.
package vrc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] VRC_CTRL_OFFSET    = 12'h214;  // vc0_resource_control
  localparam logic [11:0] VRC_STATUS_OFFSET  = 12'h218;  // table_status lives here
  localparam logic [11:0] VRC_TABLE_OFFSET   = 12'h220;  // First arbitration table entry
  localparam logic [11:0] VRC_CAP_OFFSET     = 12'h210;  // arb_capability lives here
  localparam int          VRC_ADDR_W         = 12;

  // ****************************************************************
  // Field positions and fixed values
  // ****************************************************************
  localparam int          VRC_TCMAP_LSB      = 0;
  localparam int          VRC_TCMAP_W        = 8;
  localparam logic [7:0]  VRC_TCMAP_RST      = 8'hFF;
  localparam logic [7:0]  VRC_TCMAP_WMASK    = 8'hFE;   // Bit 0 is read-only
  localparam int          VRC_LOAD_BIT       = 16;
  localparam int          VRC_SEL_LSB        = 17;
  localparam int          VRC_SEL_W          = 3;
  localparam logic [2:0]  VRC_SEL_RST        = 3'h0;
  localparam int          VRC_CHANNEL_IDENTIFIER_LSB       = 24;
  localparam logic [2:0]  VRC_CHANNEL_IDENTIFIER_VAL       = 3'h0;
  localparam int          VRC_CHANNEL_ENABLE_BIT       = 31;
  localparam logic        VRC_CHANNEL_ENABLE_VAL       = 1'b1;
  localparam int          VRC_STAT_BIT       = 16;
  localparam logic [7:0]  VRC_CAP_UP         = 8'h03;
  localparam logic [7:0]  VRC_CAP_DOWN       = 8'h01;
  localparam logic [1:0]  VRC_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  VRC_RESP_SLVERR    = 2'h2;
  localparam int          VRC_LOAD_CYCLES    = 4;       // Cycles the arbiter takes to latch a table

  // Control fields carried together to the arbitration logic
  typedef struct packed {
    logic [7:0] tc_map;
    logic [2:0] scheme;
  } vrc_ctrl_t;

endpackage : vrc_pkg

// File: logic/vrc_load_seq.sv
// Table-load sequencer: tracks table coherency and drives the copy pulse.
// Assumes a request pulse from the register slave on the same clock.
`timescale 1ns/1ps
module vrc_load_seq
  import vrc_pkg::*;
#(
  parameter int LOAD_CYCLES = VRC_LOAD_CYCLES
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic upstream,
  input  wire logic entry_written,
  input  wire logic load_req,
  output logic      copy_pulse,
  output logic      table_status
);

  initial begin
    if (LOAD_CYCLES < 1 || LOAD_CYCLES > 255) $error("LOAD_CYCLES out of range");
  end

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_COPY, SEQ_WAIT} vrc_seq_t;

  vrc_seq_t   st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic       stat_q, stat_d;
  logic       pulse_q, pulse_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    stat_d  = stat_q;
    pulse_d = 1'b0;
    if (entry_written) begin
      stat_d = 1'b1;
    end
    case (st_q)
      SEQ_IDLE: begin
        if (load_req && upstream) begin
          st_d    = SEQ_COPY;
          pulse_d = 1'b1;
        end
      end
      SEQ_COPY: begin
        st_d  = SEQ_WAIT;
        cnt_d = 8'(LOAD_CYCLES - 1);
      end
      SEQ_WAIT: begin
        if (cnt_q == 8'h00) begin
          st_d = SEQ_IDLE;
          // A write landing now re-dirties the table, so it wins
          if (!entry_written) stat_d = 1'b0;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: st_d = SEQ_IDLE;
    endcase
    if (!upstream) begin
      stat_d = 1'b0;
    end
  end

  // Registers, frozen while ce is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q    <= SEQ_IDLE;
      cnt_q   <= 8'h00;
      stat_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else if (ce) begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      stat_q  <= stat_d;
      pulse_q <= pulse_d;
    end
  end

  assign copy_pulse   = pulse_q;
  assign table_status = stat_q;

  AST_DOWN_NO_COPY: assert property (@(posedge clk) disable iff (!nrst)
    !upstream |-> !copy_pulse) else $error("copy pulse in downstream port");
  AST_DOWN_STAT_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !upstream) |=> !table_status) else $error("status set in downstream port");

endmodule // vrc_load_seq

// File: logic/vrc_ctrl_top.sv
// VC0 resource control register with AXI4-Lite slave.
// Assumes one clock domain; upstream strap is stable after reset.
// Summary of operation
// - Eight-bit class map, resets FF, bit0 fixed
// - Set map bit maps class onto channel
// - Writing one at bit16 loads arbitration table
// - Load strobe bit always reads zero
// - Load acts only in upstream port
// - Load meaningful only for table-based schemes
// - Status set on entry write, cleared after load; downstream port holds it at zero instead
// - Capability: upstream 0x3, downstream 0x1
// - Channel identifier reads zero always
// - Channel enable reads one always
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module vrc_ctrl_top
  import vrc_pkg::*;
#(
  parameter int NUM_TABLE_WORDS = 8
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        upstream_strap,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output vrc_ctrl_t        arb_ctrl,
  output logic             arb_copy,
  output logic             arb_table_status,
  output logic             arb_table_based
);

  initial begin
    if (NUM_TABLE_WORDS < 1 || NUM_TABLE_WORDS > 16) $error("NUM_TABLE_WORDS out of range");
  end

  // ****************************************************************
  // Strap capture and write channel
  // ****************************************************************
  logic        up_q, up_d;
  logic [2:0]  strap_q, strap_d;
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d;
  logic [11:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d;
  logic [7:0]  map_q, map_d;
  logic [2:0]  sel_q, sel_d;
  logic        ld_req, tbl_wr;
  logic        copy_w, stat_w;

  // Write commits once both address and data are held and no response waits
  logic do_wr;
  assign do_wr = aw_q && w_q && !bv_q;

  always_comb begin
    // Strap is a pin: three stages, and a level counts only once stages two and three agree
    strap_d = {strap_q[1:0], upstream_strap};
    up_d    = (strap_q[2] == strap_q[1]) ? strap_q[1] : up_q;
    aw_d   = aw_q;
    w_d    = w_q;
    awa_d  = awa_q;
    wd_d   = wd_q;
    ws_d   = ws_q;
    bv_d   = bv_q;
    br_d   = br_q;
    map_d  = map_q;
    sel_d  = sel_q;
    ld_req = 1'b0;
    tbl_wr = 1'b0;
    if (s_axi_awvalid && !aw_q) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = VRC_RESP_OKAY;
      if (awa_q[11:2] == VRC_CTRL_OFFSET[11:2]) begin
        // Only writable bits change; bit 0 of the map stays fixed
        if (ws_q[0]) map_d = (map_q & ~VRC_TCMAP_WMASK) | (wd_q[7:0] & VRC_TCMAP_WMASK);
        if (ws_q[2]) begin
          ld_req = wd_q[VRC_LOAD_BIT];
          sel_d  = wd_q[VRC_SEL_LSB +: VRC_SEL_W];
        end
      end else if (awa_q >= VRC_TABLE_OFFSET &&
                   awa_q < VRC_TABLE_OFFSET + 12'(4 * NUM_TABLE_WORDS)) begin
        // Entries are stored by the arbiter; here only coherency is tracked
        tbl_wr = |ws_q;
      end else if (awa_q[11:2] == VRC_STATUS_OFFSET[11:2] || awa_q[11:2] == VRC_CAP_OFFSET[11:2]) begin
        br_d = VRC_RESP_OKAY;
      end else begin
        br_d = VRC_RESP_SLVERR;
      end
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_q <= 3'h0;
      up_q  <= 1'b0;
      aw_q  <= 1'b0;
      w_q   <= 1'b0;
      awa_q <= 12'h000;
      wd_q  <= 32'h0000_0000;
      ws_q  <= 4'h0;
      bv_q  <= 1'b0;
      br_q  <= 2'h0;
      map_q <= VRC_TCMAP_RST;
      sel_q <= VRC_SEL_RST;
    end else if (ce) begin
      strap_q <= strap_d;
      up_q  <= up_d;
      aw_q  <= aw_d;
      w_q   <= w_d;
      awa_q <= awa_d;
      wd_q  <= wd_d;
      ws_q  <= ws_d;
      bv_q  <= bv_d;
      br_q  <= br_d;
      map_q <= map_d;
      sel_q <= sel_d;
    end
  end

  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;

  // ****************************************************************
  // Load sequencer
  // ****************************************************************
  vrc_load_seq #(
    .LOAD_CYCLES (VRC_LOAD_CYCLES)
  ) u_seq (
    .clk           (clk),
    .nrst          (nrst),
    .ce            (ce),
    .upstream      (up_q),
    .entry_written (tbl_wr),
    .load_req      (ld_req),
    .copy_pulse    (copy_w),
    .table_status  (stat_w)
  );

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic        rv_q, rv_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0]  rr_q, rr_d;
  logic [31:0] ctrl_word;
  logic [7:0]  cap;

  assign cap = up_q ? VRC_CAP_UP : VRC_CAP_DOWN;

  // Strobe reads zero, identifier zero, enable one, reserved zero
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[VRC_TCMAP_LSB +: VRC_TCMAP_W] = map_q;
    ctrl_word[VRC_SEL_LSB +: VRC_SEL_W]     = sel_q;
    ctrl_word[VRC_CHANNEL_IDENTIFIER_LSB +: 3]            = VRC_CHANNEL_IDENTIFIER_VAL;
    ctrl_word[VRC_CHANNEL_ENABLE_BIT]                 = VRC_CHANNEL_ENABLE_VAL;
  end

  always_comb begin
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      rr_d = VRC_RESP_OKAY;
      rd_d = 32'h0000_0000;
      if (s_axi_araddr[11:2] == VRC_CTRL_OFFSET[11:2]) begin
        rd_d = ctrl_word;
      end else if (s_axi_araddr[11:2] == VRC_STATUS_OFFSET[11:2]) begin
        rd_d[VRC_STAT_BIT] = stat_w;
      end else if (s_axi_araddr[11:2] == VRC_CAP_OFFSET[11:2]) begin
        rd_d[7:0] = cap;
      end else if (s_axi_araddr >= VRC_TABLE_OFFSET &&
                   s_axi_araddr < VRC_TABLE_OFFSET + 12'(4 * NUM_TABLE_WORDS)) begin
        rd_d = 32'h0000_0000;
      end else begin
        rr_d = VRC_RESP_SLVERR;
      end
    end
  end

  // Output registers for the arbiter side
  logic            copy_q, tstat_q, tb_q;
  vrc_ctrl_t       ctl_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rv_q    <= 1'b0;
      rd_q    <= 32'h0000_0000;
      rr_q    <= 2'h0;
      copy_q  <= 1'b0;
      tstat_q <= 1'b0;
      tb_q    <= 1'b0;
      ctl_q   <= '{tc_map: VRC_TCMAP_RST, scheme: VRC_SEL_RST};
    end else if (ce) begin
      rv_q    <= rv_d;
      rd_q    <= rd_d;
      rr_q    <= rr_d;
      copy_q  <= copy_w;
      tstat_q <= stat_w;
      // Table schemes are the weighted ones, so the copy matters only there
      tb_q    <= (sel_q != VRC_SEL_RST);
      ctl_q   <= '{tc_map: map_q, scheme: sel_q};
    end
  end

  assign s_axi_arready    = !rv_q;
  assign s_axi_rvalid     = rv_q;
  assign s_axi_rdata      = rd_q;
  assign s_axi_rresp      = rr_q;
  assign arb_copy         = copy_q;
  assign arb_table_status = tstat_q;
  assign arb_table_based  = tb_q;
  assign arb_ctrl         = ctl_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_ctrl_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == VRC_CTRL_OFFSET[11:2] && ce;
  endsequence

  sequence s_cap_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == VRC_CAP_OFFSET[11:2] && ce;
  endsequence

  AST_MAP_BIT0: assert property (@(posedge clk) disable iff (!nrst) map_q[0] == 1'b1)
    else $error("map bit 0 changed");
  AST_STROBE_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    s_ctrl_read |=> s_axi_rdata[VRC_LOAD_BIT] == 1'b0) else $error("strobe read non-zero");
  AST_CHANNEL_IDENTIFIER_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    s_ctrl_read |=> s_axi_rdata[26:24] == 3'h0) else $error("channel id non-zero");
  AST_CHANNEL_ENABLE_ONE: assert property (@(posedge clk) disable iff (!nrst)
    s_ctrl_read |=> s_axi_rdata[VRC_CHANNEL_ENABLE_BIT]) else $error("channel enable low");
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    s_ctrl_read |=> (s_axi_rdata[15:8] == 8'h00 && s_axi_rdata[23:20] == 4'h0 && s_axi_rdata[30:27] == 4'h0))
    else $error("reserved bits non-zero");
  AST_LOAD_COPY: assert property (@(posedge clk) disable iff (!nrst)
    (ld_req && up_q && ce) ##1 ce [*2] |-> arb_copy) else $error("load did not reach arbiter");
  AST_MAP_TRACK: assert property (@(posedge clk) disable iff (!nrst)
    ce |=> arb_ctrl.tc_map == $past(map_q)) else $error("map not forwarded");
  AST_CAP_VAL: assert property (@(posedge clk) disable iff (!nrst)
    s_cap_read |=> s_axi_rdata[7:0] == ($past(up_q) ? VRC_CAP_UP : VRC_CAP_DOWN)) else $error("capability wrong");

endmodule // vrc_ctrl_top

// File: dv/vrc_ctrl_top_test.sv
// Self-checking bench for the VC0 resource control register block.
// Assumes the AXI4-Lite slave and the table-load sequencer of vrc_ctrl_top.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module vrc_ctrl_top_test;
  import vrc_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk = 0, nrst = 0, strap = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic        copy, tstat, tbased, ce = 1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  vrc_ctrl_t   ctrl;
  int          fails = 0, num_checks = 0, copies = 0, c0;

  vrc_ctrl_top vrc_ctrl_top_inst (.clk(clk), .nrst(nrst), .ce(ce), .upstream_strap(strap),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .arb_ctrl(ctrl), .arb_copy(copy), .arb_table_status(tstat),
    .arb_table_based(tbased));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Count copy pulses; pre-edge sampling sees each one-cycle pulse once
  always @(posedge clk) begin
    if (copy === 1'b1) copies <= copies + 1;
  end

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    @(posedge clk);
    awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 0;
      if (wvalid && wready === 1'b1) wvalid <= 0;
      if (bvalid === 1'b1) begin r = bresp; got = 1; bready <= 0; end
    end
    if (!got) begin fails++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, 0, 1); end
  endtask

  // Read: rready held until rvalid is sampled
  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 0;
      if (rvalid === 1'b1) begin d = rdata; r = rresp; got = 1; rready <= 0; end
    end
    if (!got) begin fails++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, 0, 1); end
  endtask

  // Reset with the port strap settled while reset is held
  task automatic do_reset(input logic up);
    @(posedge clk);
    nrst <= 0; strap <= up;
    repeat (2) @(posedge clk);
    nrst <= 1;
    repeat (2) @(posedge clk);
  endtask

  // Poll status until the arbiter has latched the table; bounded
  task automatic wait_loaded();
    rd = 32'h0001_0000;
    for (int n = 0; n < 20 && rd[VRC_STAT_BIT] !== 1'b0; n++) rdr(VRC_STATUS_OFFSET, rd, rsp);
    `CHK(rd[VRC_STAT_BIT], 1'b0)
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rdr(VRC_CTRL_OFFSET, rd, rsp);
    `CHK(rd, 32'h8000_00FF)
    `CHK(ctrl, {8'hFF, 3'h0})
    `CHK(rsp, VRC_RESP_OKAY)
    $display("t_reset done");
  endtask

  // Ones into every field except map bit 0 and scheme bits 19:18: only the writable bits may take them
  task automatic t_fields();
    wr(VRC_CTRL_OFFSET, 32'hFFF3_FFFE, rsp);
    rdr(VRC_CTRL_OFFSET, rd, rsp);
    `CHK(rd, 32'h8002_00FF)
    `CHK(ctrl, {8'hFF, 3'h1})
    `CHK(tbased, 1'b1)
    wait_loaded();
    wr(VRC_CTRL_OFFSET, 32'h0000_0000, rsp);
    rdr(VRC_CTRL_OFFSET, rd, rsp);
    `CHK(rd, 32'h8000_0001)
    `CHK(ctrl, {8'h01, 3'h0})
    `CHK(tbased, 1'b0)
    $display("t_fields done");
  endtask

  // Table write flags status; zero strobe does nothing; one strobe loads once
  task automatic t_load();
    rdr(VRC_CAP_OFFSET, rd, rsp);
    `CHK(rd[7:0], VRC_CAP_UP)
    wr(VRC_TABLE_OFFSET, 32'h0000_1234, rsp);
    rdr(VRC_STATUS_OFFSET, rd, rsp);
    `CHK(rd[VRC_STAT_BIT], 1'b1)
    c0 = copies;
    wr(VRC_CTRL_OFFSET, 32'h0002_0000, rsp);
    repeat (4) @(posedge clk);
    `CHK(copies, c0)
    rdr(VRC_STATUS_OFFSET, rd, rsp);
    `CHK(rd[VRC_STAT_BIT], 1'b1)
    `CHK(tstat, 1'b1)
    wr(VRC_CTRL_OFFSET, 32'h0003_0000, rsp);
    wait_loaded();
    `CHK(copies, c0 + 1)
    `CHK(tstat, 1'b0)
    rdr(VRC_CTRL_OFFSET, rd, rsp);
    `CHK(rd, 32'h8002_0001)
    $display("t_load done");
  endtask

  // Downstream port: no load, status held at zero
  task automatic t_down();
    do_reset(1'b0);
    rdr(VRC_CAP_OFFSET, rd, rsp);
    `CHK(rd[7:0], VRC_CAP_DOWN)
    wr(VRC_TABLE_OFFSET, 32'h0000_0005, rsp);
    c0 = copies;
    wr(VRC_CTRL_OFFSET, 32'h0001_0000, rsp);
    repeat (8) @(posedge clk);
    `CHK(copies, c0)
    rdr(VRC_STATUS_OFFSET, rd, rsp);
    `CHK(rd[VRC_STAT_BIT], 1'b0)
    `CHK(tstat, 1'b0)
    $display("t_down done");
  endtask

  // Clock enable low: a read offered meanwhile must wait until ce returns
  task automatic t_freeze();
    rd = 32'h0;
    @(posedge clk);
    ce <= 0; araddr <= VRC_CAP_OFFSET; arvalid <= 1; rready <= 1;
    repeat (3) @(posedge clk);
    `CHK(rvalid, 1'b0)
    ce <= 1;
    for (int n = 0; n < 50 && rready; n++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 0;
      if (rvalid === 1'b1) begin rd = rdata; rready <= 0; end
    end
    `CHK(rd[7:0], VRC_CAP_DOWN)
    $display("t_freeze done");
  endtask

  // Unmapped address refused on both paths, register untouched
  task automatic t_unmapped();
    wr(12'h300, 32'hFFFF_FFFF, rsp);
    `CHK(rsp, VRC_RESP_SLVERR)
    rdr(12'h300, rd, rsp);
    `CHK(rsp, VRC_RESP_SLVERR)
    `CHK(rd, 32'h0)
    rdr(VRC_CTRL_OFFSET, rd, rsp);
    `CHK(rd, 32'h8000_0001)
    $display("t_unmapped done");
  endtask

  // ****************************************************************
  // Verdict, watchdog and main sequence
  // ****************************************************************
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Whole run needs around a thousand ns; allow far more before giving up
  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    do_reset(1'b1);
    t_reset();
    t_fields();
    t_load();
    t_down();
    t_freeze();
    t_unmapped();
    print_verdict();
  end
endmodule // vrc_ctrl_top_test
